//--- core/clk_ctrl_defines.svh
// Register map, field positions, reset values and counts of the clock control block
// Rules for this block and the software that drives it
// R1 - Software reads the synchronised sub-oscillator input pin level at clock mode bit 3
// R2 - Software avoids stop mode while an external clock drives either clock input
// R3 - CPU and peripheral rates come from dividing the main clock
// R4 - Reset clears every bit of the sub-oscillator control register
// R5 - Feedback cut flag 0 enables the feedback resistor, 1 disconnects it
// R6 - Drive reduce flag 1 lowers inverter drive, 0 keeps full drive
// R7 - Software keeps drive reduce at 0 below 2.7 V supply
// R8 - Unused sub clock: software writes sub-oscillator control as 0001B
// R9 - System clock bit 0 picks the source, processor clock bits 1:0 the divider
// R10 - After a selection write the old clock runs on until the switch point
// R11 - Main divider changes take at most 1/4/8/16 cycles; sub to main one; the code waits up to one old machine cycle, 64/16/8/4 main clocks
// R12 - Main to sub takes at most old machine cycle plus one sub clock period
// R13 - Software never selects the sub clock while divider setting is 01
// R14 - Software waits the full switch delay before stopping the main oscillator
// R15 - One machine cycle is one period of the selected CPU clock
// R16 - Software waits longer than the nominal switch delay
// R17 - Reset clears system and processor clock registers: slowest main speed
// R18 - On the sub clock the divider bits are ignored; CPU runs at a quarter rate
// R19 - Main oscillator stop bit acts only while the sub clock is selected
// R20 - Source changes only on clean boundaries, never a shortened CPU clock pulse
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

`define ADDR_SUB_OSC 8'h00
`define ADDR_CLK_MODE 8'h04
`define ADDR_SYS_CLK 8'h08
`define ADDR_PROC_CLK 8'h0C
`define ADDR_SW_STATUS 8'h10

`define FB_CUT_BIT 0
`define DRV_RED_BIT 1
`define PIN_STATE_BIT 3
`define SUB_SEL_BIT 0
`define OSC_STOP_BIT 3

`define SUB_OSC_RST 4'h0
`define PROC_CLK_RST 2'h0
`define SYS_CLK_RST 1'h0

`define DIV_MASK_00 6'h3F
`define DIV_MASK_01 6'h0F
`define DIV_MASK_10 6'h07
`define DIV_MASK_11 6'h03
`define PERIPH_MASK 6'h03
`define SUB_EDGES_LAST 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- core/clk_ctrl_pkg.sv
// Types shared by the clock control block
package clk_ctrl_pkg;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_WAIT_OLD = 2'h1,
        SW_WAIT_SUB = 2'h3
    } sw_state_t;

    typedef struct packed {
        axi_rsp_t rsp;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [3:0] wdata;
        logic wstrb0;
        logic [3:0] sub_oscillator_control;
        logic sub_sel;
        logic osc_stop;
        logic [1:0] processor_clock_ctrl_reg;
        logic act_sub;
        logic [1:0] act_div;
        sw_state_t sw;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic [5:0] mdiv;
        logic [1:0] sub_cnt;
        logic cpu_tick;
        logic periph_tick;
        logic fb_en;
        logic drv_red;
        logic stop_out;
    } state_t;

endpackage

//--- core/sub_osc_clk_ctrl.sv
// Sub-oscillator control and CPU clock source switch with AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "clk_ctrl_defines.svh"

module sub_osc_clk_ctrl
    import clk_ctrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input axi_req_t axi_req_i,
    output axi_rsp_t axi_rsp_o,
    input wire logic sub_osc_in_pin_i,
    output logic cpu_tick_o,
    output logic periph_tick_o,
    output logic sub_active_o,
    output logic feedback_en_o,
    output logic drive_reduce_o,
    output logic main_osc_stop_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: div_mask = `DIV_MASK_00;
            2'h1: div_mask = `DIV_MASK_01;
            2'h2: div_mask = `DIV_MASK_10;
            default: div_mask = `DIV_MASK_11;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
        read_word = 32'h0;
        case (a)
            `ADDR_SUB_OSC: read_word[3:0] = s.sub_oscillator_control;
            `ADDR_CLK_MODE: read_word[`PIN_STATE_BIT] = s.pin_s2;
            `ADDR_SYS_CLK: begin
                read_word[`SUB_SEL_BIT] = s.sub_sel;
                read_word[`OSC_STOP_BIT] = s.osc_stop;
            end
            `ADDR_PROC_CLK: read_word[1:0] = s.processor_clock_ctrl_reg;
            `ADDR_SW_STATUS: read_word[4:0] = {s.sw, s.act_div, s.act_sub};
            default: read_word = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `ADDR_SUB_OSC) || (a == `ADDR_CLK_MODE) || (a == `ADDR_SYS_CLK) ||
                 (a == `ADDR_PROC_CLK) || (a == `ADDR_SW_STATUS);
    endfunction

    state_t st_q;
    state_t st_d;
    logic sub_edge;
    logic main_tick;
    logic want_sub;
    logic [1:0] want_div;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Pin synchroniser; only the last two stages feed logic [R1]
        st_d.pin_s1 = sub_osc_in_pin_i;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_s3 = st_q.pin_s2;
        sub_edge = st_q.pin_s2 & ~st_q.pin_s3;

        // Main divider halts while the oscillator is stopped [R3]
        if (!st_q.stop_out) begin
            st_d.mdiv = st_q.mdiv + 6'h01;
        end
        main_tick = !st_q.stop_out && ((st_q.mdiv & div_mask(st_q.act_div)) ==
                    div_mask(st_q.act_div));
        st_d.periph_tick = !st_q.stop_out && ((st_q.mdiv & `PERIPH_MASK) == `PERIPH_MASK);

        // Machine cycle tick from the active source [R15] [R18]
        st_d.cpu_tick = 1'b0;
        if (st_q.act_sub) begin
            if (sub_edge) begin
                st_d.sub_cnt = st_q.sub_cnt + 2'h1;
                st_d.cpu_tick = (st_q.sub_cnt == `SUB_EDGES_LAST);
            end
        end else if (st_q.sw != SW_WAIT_SUB) begin
            st_d.cpu_tick = main_tick;
        end

        // Switch sequencer [R9] [R10]
        want_sub = st_q.sub_sel;
        want_div = st_q.processor_clock_ctrl_reg;
        case (st_q.sw)
            SW_IDLE: begin
                if (want_sub != st_q.act_sub || (!want_sub && want_div != st_q.act_div)) begin
                    st_d.sw = SW_WAIT_OLD;
                end
            end
            SW_WAIT_OLD: begin
                if (want_sub == st_q.act_sub && (want_sub || want_div == st_q.act_div)) begin
                    st_d.sw = SW_IDLE;
                end else if (st_d.cpu_tick && !st_q.osc_stop) begin
                    // Leave the old clock only at the end of its machine cycle [R11] [R20]
                    if (want_sub) begin
                        st_d.sw = SW_WAIT_SUB;
                    end else begin
                        st_d.act_sub = 1'b0;
                        st_d.act_div = want_div;
                        st_d.sw = SW_IDLE;
                    end
                end
            end
            SW_WAIT_SUB: begin
                // Join the sub clock on its own rising edge [R12] [R20]
                if (sub_edge) begin
                    st_d.act_sub = 1'b1;
                    st_d.sub_cnt = 2'h1;
                    st_d.sw = SW_IDLE;
                end
            end
            default: st_d.sw = SW_IDLE;
        endcase

        // Bus: write address and data in either order
        if (axi_req_i.awvalid && st_q.rsp.awready) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st_q.rsp.wready) begin
            st_d.w_got = 1'b1;
            st_d.wdata = axi_req_i.wdata[3:0];
            st_d.wstrb0 = axi_req_i.wstrb[0];
        end
        if (st_q.rsp.bvalid && axi_req_i.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.rsp.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp = mapped(st_q.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
            if (st_q.wstrb0) begin
                case (st_q.awaddr)
                    `ADDR_SUB_OSC: st_d.sub_oscillator_control = st_q.wdata;
                    `ADDR_SYS_CLK: begin
                        st_d.sub_sel = st_q.wdata[`SUB_SEL_BIT];
                        // Stop accepted only while running on the sub clock [R19]
                        st_d.osc_stop = st_q.wdata[`OSC_STOP_BIT] & st_q.act_sub &
                                        st_q.sub_sel;
                    end
                    `ADDR_PROC_CLK: st_d.processor_clock_ctrl_reg = st_q.wdata[1:0];
                    default: st_d.sub_oscillator_control = st_q.sub_oscillator_control;
                endcase
            end
        end
        st_d.rsp.awready = !st_d.aw_got && !st_d.rsp.bvalid;
        st_d.rsp.wready = !st_d.w_got && !st_d.rsp.bvalid;

        // Bus: read
        if (st_q.rsp.rvalid && axi_req_i.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && st_q.rsp.arready) begin
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rdata = read_word(st_q, axi_req_i.araddr);
            st_d.rsp.rresp = mapped(axi_req_i.araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        st_d.rsp.arready = !st_d.rsp.rvalid;

        // Oscillator controls [R5] [R6]
        st_d.fb_en = !st_d.sub_oscillator_control[`FB_CUT_BIT];
        st_d.drv_red = st_d.sub_oscillator_control[`DRV_RED_BIT];
        st_d.stop_out = st_d.osc_stop;

        if (!rst_n_i) begin
            st_d = '0;
            st_d.sub_oscillator_control = `SUB_OSC_RST;                        // [R4]
            st_d.processor_clock_ctrl_reg = `PROC_CLK_RST;                       // [R17]
            st_d.sub_sel = `SYS_CLK_RST;                    // [R17]
            st_d.act_div = `PROC_CLK_RST;
            st_d.sw = SW_IDLE;
            st_d.fb_en = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign axi_rsp_o = st_q.rsp;
    assign cpu_tick_o = st_q.cpu_tick;
    assign periph_tick_o = st_q.periph_tick;
    assign sub_active_o = st_q.act_sub;
    assign feedback_en_o = st_q.fb_en;
    assign drive_reduce_o = st_q.drv_red;
    assign main_osc_stop_o = st_q.stop_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_reset_clears_regs: assert property ( // [R4] [R17]
        $past(!rst_n_i) |-> (st_q.sub_oscillator_control == 4'h0 && st_q.processor_clock_ctrl_reg == 2'h0 && !st_q.sub_sel &&
                             !st_q.act_sub && !main_osc_stop_o))
        else $error("registers not cleared by reset");

    chk_feedback_flag: assert property ( // [R5]
        feedback_en_o == !st_q.sub_oscillator_control[`FB_CUT_BIT])
        else $error("feedback enable disagrees with cut flag");

    chk_drive_flag: assert property ( // [R6]
        drive_reduce_o == st_q.sub_oscillator_control[`DRV_RED_BIT])
        else $error("drive reduce disagrees with flag");

    chk_fast_cycle: assert property ( // [R15] [R3]
        (cpu_tick_o && !st_q.act_sub && st_q.act_div == 2'h3 && st_q.sw == SW_IDLE &&
         !main_osc_stop_o) |-> ##1 !cpu_tick_o [*3] ##1 cpu_tick_o)
        else $error("fastest machine cycle is not four clocks");

    chk_main_switch_bound: assert property ( // [R11] [R10]
        (st_q.sw == SW_IDLE ##1 st_q.sw == SW_WAIT_OLD && !st_q.sub_sel && !st_q.act_sub)
        |-> ##[0:64] st_q.sw == SW_IDLE)
        else $error("main divider change took too long");

    chk_sub_quarter: assert property ( // [R18]
        (st_q.act_sub && sub_edge && st_q.sub_cnt == `SUB_EDGES_LAST && st_q.sw == SW_IDLE)
        |=> cpu_tick_o)
        else $error("sub clock machine cycle is not four edges");

    chk_stop_on_sub: assert property ( // [R19]
        main_osc_stop_o |-> (st_q.act_sub && st_q.sub_sel))
        else $error("main oscillator stopped while not on sub clock");

    chk_clean_main_switch: assert property ( // [R20]
        ($changed(st_q.act_div) || $fell(st_q.act_sub)) |-> cpu_tick_o)
        else $error("main clock selection changed mid cycle");

    chk_clean_sub_entry: assert property ( // [R20] [R12]
        $rose(st_q.act_sub) |-> $past(st_q.sw) == SW_WAIT_SUB && $past(sub_edge))
        else $error("sub clock joined off an edge");

    chk_periph_spacing: assert property ( // [R3]
        periph_tick_o |=> !periph_tick_o [*3])
        else $error("peripheral ticks closer than four clocks");

    chk_sub_ignores_div: assert property ( // [R18]
        (sub_active_o && st_q.sub_sel && $changed(st_q.processor_clock_ctrl_reg)) |=> sub_active_o)
        else $error("divider write moved the clock off the sub source");

    chk_sub_follows_sel: assert property ( // [R9]
        $rose(sub_active_o) |-> st_q.sub_sel)
        else $error("sub clock joined without its select bit");

    chk_pin_sync: assert property ( // [R1]
        ($past(rst_n_i) && $past(rst_n_i, 2)) |-> st_q.pin_s2 == $past(sub_osc_in_pin_i, 2))
        else $error("pin synchroniser is not two stages");

    chk_pin_readback: assert property ( // [R1]
        (axi_req_i.arvalid && axi_rsp_o.arready && axi_req_i.araddr == `ADDR_CLK_MODE)
        |=> axi_rsp_o.rdata[`PIN_STATE_BIT] == $past(st_q.pin_s2))
        else $error("clock mode bit 3 does not show pin level");

endmodule // sub_osc_clk_ctrl

//--- dv/testbench.sv
// Self-checking bench for the sub-oscillator and clock switch block
`timescale 1ns/100ps
`include "clk_ctrl_defines.svh"

module testbench
    import clk_ctrl_pkg::*;
;
// ----
// Signals and block
// ----
logic mclk_i;
logic rst_n_i;
axi_req_t req;
axi_rsp_t rsp;
logic sub_pin = 1'b0;
logic pin_lvl = 1'b0;
logic sub_run = 1'b0;
int sub_cnt = 0;
logic cpu_tick, periph_tick, sub_active, fb_en, drv_red, osc_stop;
int mismatches = 0;
int samples_checked = 0;

sub_osc_clk_ctrl sub_osc_clk_ctrl_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .sub_osc_in_pin_i(sub_pin),
    .cpu_tick_o(cpu_tick),
    .periph_tick_o(periph_tick),
    .sub_active_o(sub_active),
    .feedback_en_o(fb_en),
    .drive_reduce_o(drv_red),
    .main_osc_stop_o(osc_stop)
);

initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
end

// Sub clock source, period 20 mclk while running
always @(posedge mclk_i) begin
    if (sub_run) begin
        sub_cnt <= (sub_cnt == 9) ? 0 : sub_cnt + 1;
        if (sub_cnt == 9) begin
            sub_pin <= ~sub_pin;
        end
    end else begin
        sub_pin <= pin_lvl;
    end
end
// ----
// Tasks
// ----
task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask

task automatic timed_out(input string what);
    mismatches++;
    $display("mismatch %s expected answer seen none", what);
    close_out();
endtask

task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
        mismatches++;
        $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
endtask

task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp(what, {31'h0, exp}, {31'h0, got});
endtask

function automatic logic sig(input int sel);
    return (sel == 0) ? cpu_tick : ((sel == 1) ? periph_tick : sub_active);
endfunction

task automatic wr(input logic [7:0] a, input logic [3:0] d, output logic [1:0] resp);
    int n;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    resp = 2'h1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {28'h0000000, d};
    for (n = 0; n < 200; n++) begin
        @(posedge mclk_i);
        if (aw_done && w_done && rsp.bvalid === 1'b1) begin
            resp = rsp.bresp;
            break;
        end
        if (!aw_done && rsp.awready === 1'b1) begin
            aw_done = 1'b1;
            req.awvalid <= 1'b0;
        end
        if (!w_done && rsp.wready === 1'b1) begin
            w_done = 1'b1;
            req.wvalid <= 1'b0;
        end
    end
    if (n == 200) timed_out("write");
endtask

task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] exp_resp);
    int n;
    logic taken;
    taken = 1'b0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    for (n = 0; n < 200; n++) begin
        @(posedge mclk_i);
        if (taken && rsp.rvalid === 1'b1) begin
            cmp(what, exp, rsp.rdata);
            cmp(what, {30'h0, exp_resp}, {30'h0, rsp.rresp});
            break;
        end
        if (!taken && rsp.arready === 1'b1) begin
            taken = 1'b1;
            req.arvalid <= 1'b0;
        end
    end
    if (n == 200) timed_out("read");
endtask

task automatic wait_lvl(input int sel, input logic v, output int n);
    for (n = 0; n < 1000; n++) begin
        @(posedge mclk_i);
        if (sig(sel) === v) break;
    end
    if (n == 1000) timed_out("wait");
endtask

task automatic gap(input int sel, output int g);
    int n;
    logic seen;
    seen = 1'b0;
    g = 0;
    for (n = 0; n < 600; n++) begin
        @(posedge mclk_i);
        if (sig(sel) === 1'b1) begin
            if (seen) begin
                g++;
                break;
            end
            seen = 1'b1;
            g = 0;
        end else begin
            g++;
        end
    end
    if (n == 600) timed_out("tick");
endtask
// ----
// Test sequence
// ----
initial begin
    int per[4] = '{64, 16, 8, 4};
    logic [1:0] seq[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [3:0] sub_oscillator_control[4] = '{4'h3, 4'h2, 4'h1, 4'h0};
    logic [1:0] resp;
    logic any;
    int g;
    int n;
    int old;
    rst_n_i = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    cmp_bit("feedback_en", 1'b1, fb_en);
    cmp_bit("drive_reduce", 1'b0, drv_red);
    cmp_bit("sub_active", 1'b0, sub_active);
    chk_rd("sub_osc", `ADDR_SUB_OSC, 32'h0, 2'h0);
    chk_rd("sys_clk", `ADDR_SYS_CLK, 32'h0, 2'h0);
    chk_rd("proc_clk", `ADDR_PROC_CLK, 32'h0, 2'h0);
    gap(0, g);
    cmp("reset_cycle", 32'(64), 32'(g));
    gap(1, g);
    cmp("periph_cycle", 32'(4), 32'(g));
    foreach (sub_oscillator_control[i]) begin
        wr(`ADDR_SUB_OSC, sub_oscillator_control[i], resp);
        repeat (2) @(posedge mclk_i);
        cmp_bit("feedback_en", ~sub_oscillator_control[i][0], fb_en);
        cmp_bit("drive_reduce", sub_oscillator_control[i][1], drv_red);
        chk_rd("sub_osc", `ADDR_SUB_OSC, {28'h0, sub_oscillator_control[i]}, 2'h0);
    end
    wr(8'h14, 4'hF, resp);
    cmp("bad_wr_resp", 32'h2, {30'h0, resp});
    chk_rd("bad_rd", 8'h14, 32'h0, 2'h2);
    chk_rd("sub_osc", `ADDR_SUB_OSC, 32'h0, 2'h0);
    req.wstrb <= 4'h0;
    wr(`ADDR_SUB_OSC, 4'h5, resp);
    req.wstrb <= 4'hF;
    cmp("nostrb_resp", 32'h0, {30'h0, resp});
    chk_rd("nostrb", `ADDR_SUB_OSC, 32'h0, 2'h0);
    pin_lvl <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk_rd("pin_high", `ADDR_CLK_MODE, 32'h8, 2'h0);
    pin_lvl <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk_rd("pin_low", `ADDR_CLK_MODE, 32'h0, 2'h0);
    old = 0;
    foreach (seq[i]) begin
        wr(`ADDR_PROC_CLK, {2'h0, seq[i]}, resp);
        wait_lvl(0, 1'b1, n);
        cmp_bit("switch_delay", 1'b1, n <= per[old] + 3);
        gap(0, g);
        gap(0, g);
        cmp("machine_cycle", 32'(per[seq[i]]), 32'(g));
        chk_rd("status", `ADDR_SW_STATUS, {29'h0, seq[i], 1'b0}, 2'h0);
        old = seq[i];
    end
    wr(`ADDR_SYS_CLK, 4'h8, resp);
    repeat (3) @(posedge mclk_i);
    cmp_bit("stop_on_main", 1'b0, osc_stop);
    chk_rd("sys_clk", `ADDR_SYS_CLK, 32'h0, 2'h0);
    wr(`ADDR_PROC_CLK, 4'h3, resp);
    gap(0, g);
    sub_run <= 1'b1;
    wr(`ADDR_SYS_CLK, 4'h1, resp);
    wait_lvl(2, 1'b1, n);
    cmp_bit("to_sub_delay", 1'b1, n <= 30);
    gap(0, g);
    cmp("sub_cycle", 32'(80), 32'(g));
    wr(`ADDR_PROC_CLK, 4'h0, resp);
    gap(0, g);
    cmp("sub_cycle_div", 32'(80), 32'(g));
    gap(0, g);
    wr(`ADDR_SYS_CLK, 4'h9, resp);
    repeat (3) @(posedge mclk_i);
    cmp_bit("stop_on_sub", 1'b1, osc_stop);
    any = 1'b0;
    repeat (8) begin
        @(posedge mclk_i);
        any = any | periph_tick;
    end
    cmp_bit("periph_halt", 1'b0, any);
    gap(0, g);
    cmp("sub_cycle_stop", 32'(80), 32'(g));
    wr(`ADDR_SYS_CLK, 4'h0, resp);
    wait_lvl(2, 1'b0, n);
    cmp_bit("to_main_delay", 1'b1, n <= 110);
    cmp_bit("stop_clear", 1'b0, osc_stop);
    gap(0, g);
    gap(0, g);
    cmp("main_again", 32'(64), 32'(g));
    close_out();
end

endmodule // testbench
